// ### design/qrd_defines.svh
/*
 * Constants of the quad read / burst-wrap front end: opcodes, phase lengths,
 * field positions and reset values.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef QRD_DEFINES_SVH
`define QRD_DEFINES_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define QRD_OP_QREAD 8'hEB
`define QRD_OP_QWORD 8'hE7
`define QRD_OP_SETWRAP 8'h77

// ****************************************************************
// phase lengths in serial clocks; the command entry is its last count, 7 of its 8 clocks
// ****************************************************************
`define QRD_CMD_CLKS 6'h07
`define QRD_ADDR_CLKS 6'h06
`define QRD_MODE_CLKS 6'h02
`define QRD_DUMMY_QREAD 6'h04
`define QRD_DUMMY_QWORD 6'h02
`define QRD_WRAP_CLKS 6'h20

// ****************************************************************
// field positions and codes
// ****************************************************************
`define QRD_QE_BIT 9
`define QRD_KEEP_HI 5
`define QRD_KEEP_LO 4
`define QRD_KEEP_CODE 2'b10
`define QRD_WRAP_DIS_BIT 4
`define QRD_WRAP_LEN_HI 6
`define QRD_WRAP_LEN_LO 5
`define QRD_WRAP_MIN_MASK 8'h07

// ****************************************************************
// reset values
// ****************************************************************
`define QRD_WRAP_DIS_RST 1'b1
`define QRD_WRAP_LEN_RST 2'b00
`define QRD_MODE_RST 8'h00

`endif

// ### design/qrd_pkg.sv
/*
 * Types shared by the quad read front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package qrd_pkg;

    // one-hot phases of a frame on the serial link
    typedef enum logic [7:0] {
        ST_START  = 8'b0000_0001,
        ST_CMD    = 8'b0000_0010,
        ST_ADDR   = 8'b0000_0100,
        ST_MODE   = 8'b0000_1000,
        ST_DUMMY  = 8'b0001_0000,
        ST_DATA   = 8'b0010_0000,
        ST_WBITS  = 8'b0100_0000,
        ST_IGNORE = 8'b1000_0000
    } link_state_t;

endpackage

// ### design/quad_io_read_wrap_front_end.sv
/*
 * Quad-lane read front end of a serial flash: quad fast read, quad word read,
 * continuous read mode and burst-with-wrap setting.
 * Assumes: the array answers i_array_data combinationally from o_array_addr;
 * the host owns chip select and serial clock; i_status_word, i_crm_reset and
 * the status outputs live on i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qrd_defines.svh"

module quad_io_read_wrap_front_end
    import qrd_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    // system side
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [15:0] i_status_word,
    input wire logic i_crm_reset,
    output logic o_wrap_disable,
    output logic [1:0] o_wrap_len,
    output logic o_crm_keep,
    // serial link
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_qd,
    output logic [3:0] o_qd,
    output logic [3:0] o_qd_oe,
    // array
    output logic [ADDR_W-1:0] o_array_addr,
    input wire logic [7:0] i_array_data
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // wrap needs at least a page of low bits; address phase carries 24
    generate
        if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_addr_w
            $error("ADDR_W must lie between 8 and 24");
        end
    endgenerate

    // ****************************************************************
    // reference domain: mode-reset event and status reporting
    // ****************************************************************
    logic crm_tgl_q, crm_tgl_d;
    logic [2:0] st_s1_q, st_s2_q, st_s3_q;
    logic [2:0] st_out_q, st_out_d;
    logic wrap_dis_q, crm_keep_lnk;
    logic [1:0] wrap_len_q;

    always_comb begin
        crm_tgl_d = crm_tgl_q ^ i_crm_reset;
        st_out_d = st_out_q;
        if (st_s2_q == st_s3_q) begin
            st_out_d = st_s3_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crm_tgl_q <= 1'b0;
            st_s1_q <= {`QRD_WRAP_DIS_RST, `QRD_WRAP_LEN_RST};
            st_s2_q <= {`QRD_WRAP_DIS_RST, `QRD_WRAP_LEN_RST};
            st_s3_q <= {`QRD_WRAP_DIS_RST, `QRD_WRAP_LEN_RST};
            st_out_q <= {`QRD_WRAP_DIS_RST, `QRD_WRAP_LEN_RST};
        end else if (i_clk_en) begin
            crm_tgl_q <= crm_tgl_d;
            st_s1_q <= {wrap_dis_q, wrap_len_q};
            st_s2_q <= st_s1_q;
            st_s3_q <= st_s2_q;
            st_out_q <= st_out_d;
        end
    end

    // keep flag reported through its own three-stage chain
    logic ck_s1_q, ck_s2_q, ck_s3_q, ck_out_q, ck_out_d;

    always_comb begin
        ck_out_d = (ck_s2_q == ck_s3_q) ? ck_s3_q : ck_out_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            ck_out_q <= 1'b0;
        end else if (i_clk_en) begin
            ck_s1_q <= crm_keep_lnk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            ck_out_q <= ck_out_d;
        end
    end

    assign o_wrap_disable = st_out_q[2];
    assign o_wrap_len = st_out_q[1:0];
    assign o_crm_keep = ck_out_q;

    // ****************************************************************
    // link domain: crossings in and persistent settings
    // ****************************************************************
    // these survive chip select; the link clock only runs inside frames,
    // so a mode reset is applied at the first edges of the next frame
    logic qe_s1_q, qe_s2_q, qe_s3_q, qe_q, qe_d;
    logic rt_s1_q, rt_s2_q, rt_s3_q, rt_seen_q, rt_seen_d;
    logic [7:0] crm_q, crm_d;
    logic crm_word_q, crm_word_d;
    logic [1:0] wrap_len_d;
    logic wrap_dis_d;
    logic mode_cap, wrap_cap, crm_clr;
    logic [7:0] mode_val, wrap_val;
    logic word_cmd_q;

    always_comb begin
        qe_d = (qe_s2_q == qe_s3_q) ? qe_s3_q : qe_q;
        rt_seen_d = rt_seen_q;
        crm_clr = 1'b0;
        if (rt_s2_q == rt_s3_q && rt_s3_q != rt_seen_q) begin
            rt_seen_d = rt_s3_q;
            crm_clr = 1'b1;
        end
        crm_d = crm_q;
        crm_word_d = crm_word_q;
        if (crm_clr) begin
            crm_d = `QRD_MODE_RST;
        end
        // a mode byte arriving with the reset wins
        if (mode_cap) begin
            crm_d = mode_val;
            crm_word_d = word_cmd_q;
        end
        wrap_dis_d = wrap_dis_q;
        wrap_len_d = wrap_len_q;
        if (wrap_cap) begin
            wrap_dis_d = wrap_val[`QRD_WRAP_DIS_BIT];
            wrap_len_d = wrap_val[`QRD_WRAP_LEN_HI:`QRD_WRAP_LEN_LO];
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qe_s1_q <= 1'b0;
            qe_s2_q <= 1'b0;
            qe_s3_q <= 1'b0;
            qe_q <= 1'b0;
            rt_s1_q <= 1'b0;
            rt_s2_q <= 1'b0;
            rt_s3_q <= 1'b0;
            rt_seen_q <= 1'b0;
            crm_q <= `QRD_MODE_RST;
            crm_word_q <= 1'b0;
            wrap_dis_q <= `QRD_WRAP_DIS_RST;
            wrap_len_q <= `QRD_WRAP_LEN_RST;
        end else begin
            qe_s1_q <= i_status_word[`QRD_QE_BIT];
            qe_s2_q <= qe_s1_q;
            qe_s3_q <= qe_s2_q;
            qe_q <= qe_d;
            rt_s1_q <= crm_tgl_q;
            rt_s2_q <= rt_s1_q;
            rt_s3_q <= rt_s2_q;
            rt_seen_q <= rt_seen_d;
            crm_q <= crm_d;
            crm_word_q <= crm_word_d;
            wrap_dis_q <= wrap_dis_d;
            wrap_len_q <= wrap_len_d;
        end
    end

    // only bits 5:4 of the mode byte decide the next frame's format
    assign crm_keep_lnk = (crm_q[`QRD_KEEP_HI:`QRD_KEEP_LO] == `QRD_KEEP_CODE);

    // ****************************************************************
    // link domain: frame sequencer on rising edges
    // ****************************************************************
    // frame state is cleared while select is high, whatever the clock does
    logic frame_rst_n;
    assign frame_rst_n = i_rst_n & ~i_cs_n;

    link_state_t state_q, state_d;
    logic [5:0] cnt_q, cnt_d;
    logic [31:0] sh_q, sh_d;
    logic [ADDR_W-1:0] addr_q, addr_d, addr_inc;
    logic phase_q, phase_d;
    logic word_cmd_d;
    logic [7:0] op_val;
    logic [23:0] addr_val;
    logic [ADDR_W-1:0] wrap_mask;

    always_comb begin
        wrap_mask = {ADDR_W{1'b0}};
        // shifted mask keeps its low ones so every size is 2^n - 1
        wrap_mask[7:0] = (`QRD_WRAP_MIN_MASK << wrap_len_q) | `QRD_WRAP_MIN_MASK;
        // whole-array wrap falls out of the counter width
        if (wrap_dis_q) begin
            addr_inc = addr_q + 1'b1;
        end else begin
            addr_inc = (addr_q & ~wrap_mask) | ((addr_q + 1'b1) & wrap_mask);
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        sh_d = {sh_q[27:0], i_qd};
        addr_d = addr_q;
        phase_d = phase_q;
        word_cmd_d = word_cmd_q;
        mode_cap = 1'b0;
        wrap_cap = 1'b0;
        op_val = {sh_q[6:0], i_qd[0]};
        addr_val = {sh_q[19:0], i_qd};
        mode_val = {sh_q[3:0], i_qd};
        wrap_val = {sh_q[6:0], i_qd[0]};
        case (state_q)
            ST_START: begin
                cnt_d = 6'h01;
                if (crm_keep_lnk) begin
                    state_d = ST_ADDR;
                    word_cmd_d = crm_word_q;
                end else begin
                    sh_d = {31'h0000_0000, i_qd[0]};
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                sh_d = {sh_q[30:0], i_qd[0]};
                if (cnt_q == `QRD_CMD_CLKS) begin
                    cnt_d = 6'h00;
                    if ((op_val == `QRD_OP_QREAD || op_val == `QRD_OP_QWORD) && qe_q) begin
                        state_d = ST_ADDR;
                        word_cmd_d = (op_val == `QRD_OP_QWORD);
                    end else if (op_val == `QRD_OP_SETWRAP) begin
                        state_d = ST_WBITS;
                    end else begin
                        state_d = ST_IGNORE;
                    end
                end
            end
            ST_ADDR: begin
                if (cnt_q == `QRD_ADDR_CLKS - 6'h01) begin
                    cnt_d = 6'h00;
                    addr_d = addr_val[ADDR_W-1:0];
                    state_d = ST_MODE;
                end
            end
            ST_MODE: begin
                if (cnt_q == `QRD_MODE_CLKS - 6'h01) begin
                    cnt_d = 6'h00;
                    mode_cap = 1'b1;
                    state_d = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                if (cnt_q == (word_cmd_q ? `QRD_DUMMY_QWORD : `QRD_DUMMY_QREAD) - 6'h01) begin
                    phase_d = 1'b0;
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                phase_d = ~phase_q;
                if (phase_q) begin
                    addr_d = addr_inc;
                end
            end
            ST_WBITS: begin
                sh_d = {sh_q[30:0], i_qd[0]};
                if (cnt_q == `QRD_WRAP_CLKS - 6'h01) begin
                    wrap_cap = 1'b1;
                    state_d = ST_IGNORE;
                end
            end
            ST_IGNORE: begin
                cnt_d = cnt_q;
            end
            default: begin
                state_d = ST_IGNORE;
            end
        endcase
    end

    always_ff @(posedge i_sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_q <= ST_START;
            cnt_q <= 6'h00;
            sh_q <= 32'h0000_0000;
            phase_q <= 1'b0;
            word_cmd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            phase_q <= phase_d;
            word_cmd_q <= word_cmd_d;
        end
    end

    // address survives select so the array port stays steady between frames
    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q <= {ADDR_W{1'b0}};
        end else begin
            addr_q <= addr_d;
        end
    end

    assign o_array_addr = addr_q;

    // ****************************************************************
    // link domain: output drivers on falling edges
    // ****************************************************************
    logic [3:0] qd_q, qd_d, oe_q, oe_d, low_q, low_d;

    always_comb begin
        qd_d = 4'h0;
        oe_d = 4'h0;
        low_d = low_q;
        if (state_q == ST_DATA) begin
            oe_d = 4'hF;
            if (!phase_q) begin
                qd_d = i_array_data[7:4];
                low_d = i_array_data[3:0];
            end else begin
                qd_d = low_q;
            end
        end
    end

    always_ff @(negedge i_sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            qd_q <= 4'h0;
            oe_q <= 4'h0;
            low_q <= 4'h0;
        end else begin
            qd_q <= qd_d;
            oe_q <= oe_d;
            low_q <= low_d;
        end
    end

    assign o_qd = qd_q;
    assign o_qd_oe = oe_q;

endmodule

`default_nettype wire

// ### sim/qrd_host_model.sv
/*
 * Host controller model: drives select, serial clock and the shared lines.
 * Assumes the caller runs one frame at a time; clock stops between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module qrd_host_model (
    // link toward the device
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_qd,
    // device drive
    input wire logic [3:0] i_qd,
    input wire logic [3:0] i_qd_oe
);
    logic [3:0] drv = 4'h0;
    logic drv_en = 1'b0;
    logic [3:0] seen_oe;
    logic [7:0] rd [0:127];
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
    end
    // released lanes show the inverse, so stale values never pass
    assign o_qd = (i_qd & i_qd_oe) | (~i_qd_oe & (drv_en ? drv : ~drv));
    task automatic tick(input logic [3:0] n);
        drv = n;
        #62.5 o_sck = 1'b1;
        #62.5 o_sck = 1'b0;
    endtask
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) tick({3'b000, v[i]});
    endtask
    task automatic frame_end;
        #62.5 o_cs_n = 1'b1;
        drv_en = 1'b0;
        #200;
    endtask
    task automatic idle(input int n);
        o_cs_n = 1'b0;
        drv_en = 1'b1;
        repeat (n) tick(4'hF);
        frame_end();
    endtask
    task automatic wrap_set(input logic [7:0] w);
        o_cs_n = 1'b0;
        drv_en = 1'b1;
        bits(32'h0000_0077, 8);
        bits(32'h0000_0000, 24);
        bits({24'h00_0000, w}, 8);
        frame_end();
    endtask
    // op 00 leaves the opcode out, as continuous mode allows
    task automatic read(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m, input int dum, input int nib);
        logic [3:0] hi;
        o_cs_n = 1'b0;
        drv_en = 1'b1;
        seen_oe = 4'h0;
        if (op != 8'h00) bits({24'h00_0000, op}, 8);
        for (int i = 5; i >= 0; i--) tick(a[i*4 +: 4]);
        tick(m[7:4]);
        tick(m[3:0]);
        drv_en = 1'b0;
        for (int i = 0; i < dum; i++) tick(4'h0);
        for (int i = 0; i < nib; i++) begin
            #1 seen_oe = seen_oe | i_qd_oe;
            if (i % 2) rd[i/2] = {hi, i_qd};
            else hi = i_qd;
            tick(4'h0);
        end
        frame_end();
    endtask
endmodule
`default_nettype wire

// ### sim/quad_io_read_wrap_front_end_properties.sv
/*
 * Concurrent checks of the quad read front end, bound to its top module.
 * Assumes only the top ports; every check runs on i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module qrd_checker
    import qrd_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    // system side
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_status_word,
    input wire logic o_wrap_disable,
    input wire logic [1:0] o_wrap_len,
    input wire logic o_crm_keep,
    // serial link and array
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] o_qd,
    input wire logic [3:0] o_qd_oe,
    input wire logic [ADDR_W-1:0] o_array_addr
);
    logic [7:0] qe_low_q;
    logic [ADDR_W-1:0] wmask;
    logic data_on;
    assign wmask = ADDR_W'((32'd8 << o_wrap_len) - 32'd1);
    assign data_on = o_qd_oe == 4'hF;
    // ****************************************************************
    // quad enable low time, long enough to have crossed
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n || i_status_word[9]) begin
            qe_low_q <= 8'h00;
        end else if (qe_low_q != 8'hFF) begin
            qe_low_q <= qe_low_q + 8'h01;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_release;
        $rose(i_rst_n);
    endsequence
    sequence s_step;
        $changed(o_array_addr) && data_on && $past(o_qd_oe) == 4'hF;
    endsequence
    a_reset_values: assert property (s_release |-> o_wrap_disable && o_wrap_len == 2'b00 && !o_crm_keep)
        else $error("settings not at reset values");
    a_cs_release: assert property (i_cs_n |-> o_qd_oe == 4'h0)
        else $error("lines driven while deselected");
    a_all_lanes: assert property (o_qd_oe == 4'h0 || data_on)
        else $error("partial lane drive");
    a_nibble_fall: assert property (data_on && $changed(o_qd) |-> !i_sck)
        else $error("data changed outside low clock phase");
    a_addr_rise: assert property ($changed(o_array_addr) |-> i_sck || i_cs_n)
        else $error("address changed outside high clock phase");
    a_addr_step: assert property (s_step and o_wrap_disable |-> o_array_addr == ADDR_W'($past(o_array_addr) + 1'b1))
        else $error("address did not step by one");
    a_wrap_step: assert property (s_step and !o_wrap_disable |->
        ((o_array_addr ^ $past(o_array_addr)) & ~wmask) == '0 &&
        (o_array_addr & wmask) == (ADDR_W'($past(o_array_addr) + 1'b1) & wmask))
        else $error("wrapped address left its section");
    a_quad_gate: assert property (qe_low_q > 8'hC8 |-> o_qd_oe == 4'h0)
        else $error("lines driven with quad disabled");
endmodule
bind quad_io_read_wrap_front_end qrd_checker #(.ADDR_W(ADDR_W)) u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_status_word(i_status_word), .o_wrap_disable(o_wrap_disable), .o_wrap_len(o_wrap_len),
    .o_crm_keep(o_crm_keep), .i_sck(i_sck), .i_cs_n(i_cs_n), .o_qd(o_qd), .o_qd_oe(o_qd_oe),
    .o_array_addr(o_array_addr));
`default_nettype wire

// ### sim/quad_io_read_wrap_front_end_tb_top.sv
/*
 * Self-checking bench of the quad read front end with a host model.
 * Assumes a combinational array model and the checker bound to the top.
 */
`timescale 1ns/1ps
`default_nettype none
module quad_io_read_wrap_front_end_tb_top;
    import qrd_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_crm_reset = 1'b0;
    logic [15:0] i_status_word = 16'h0200;
    logic i_sck, i_cs_n, o_wrap_disable, o_crm_keep;
    logic [3:0] i_qd, o_qd, o_qd_oe;
    logic [1:0] o_wrap_len;
    logic [18:0] o_array_addr;
    logic [7:0] i_array_data;
    int fails = 0;
    int n_compared = 0;
    int wl = -1;
    always #2 i_ref_clk = ~i_ref_clk;
    function automatic logic [7:0] dat(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    assign i_array_data = dat(o_array_addr);
    quad_io_read_wrap_front_end #(.ADDR_W(19)) dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
        .i_status_word(i_status_word), .i_crm_reset(i_crm_reset), .o_wrap_disable(o_wrap_disable),
        .o_wrap_len(o_wrap_len), .o_crm_keep(o_crm_keep), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_qd(i_qd),
        .o_qd(o_qd), .o_qd_oe(o_qd_oe), .o_array_addr(o_array_addr), .i_array_data(i_array_data));
    qrd_host_model host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_qd(i_qd), .i_qd(o_qd), .i_qd_oe(o_qd_oe));
    // ****************************************************************
    // comparisons and helpers
    // ****************************************************************
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic settle;
        repeat (8) @(posedge i_ref_clk);
    endtask
    task automatic stream(input logic [18:0] a, input int n);
        logic [18:0] m;
        m = (wl < 0) ? '1 : 19'((8 << wl) - 1);
        for (int i = 0; i < n; i++) chk_data(host.rd[i], dat((a & ~m) | ((a + 19'(i)) & m)), "byte");
    endtask
    task automatic keep_is(input logic k, input string what);
        settle();
        chk_flag({3'b000, o_crm_keep}, {3'b000, k}, what);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_rollover;
        host.read(8'hEB, 24'h07_FFFE, 8'h00, 4, 8);
        stream(19'h7_FFFE, 4);
    endtask
    task automatic t_word;
        host.read(8'hE7, 24'h01_2340, 8'h00, 2, 6);
        stream(19'h1_2340, 3);
    endtask
    task automatic t_refused;
        @(posedge i_ref_clk) i_status_word <= 16'hFDFF;
        host.idle(5);
        host.read(8'hEB, 24'h00_0010, 8'h00, 4, 4);
        chk_flag(host.seen_oe, 4'h0, "quad read refused");
        host.read(8'hE7, 24'h00_0010, 8'h00, 2, 4);
        chk_flag(host.seen_oe, 4'h0, "word read refused");
        @(posedge i_ref_clk) i_status_word <= 16'h0200;
        host.idle(5);
    endtask
    task automatic t_keep(input logic [7:0] op, input int dum);
        host.read(op, 24'h00_0400, 8'h2F, dum, 4);
        stream(19'h0_0400, 2);
        keep_is(1'b1, "keep set");
        host.read(8'h00, 24'h00_0500, 8'h10, dum, 4);
        stream(19'h0_0500, 2);
        keep_is(1'b0, "keep cleared");
        host.read(op, 24'h00_0600, 8'h00, dum, 4);
        stream(19'h0_0600, 2);
    endtask
    task automatic t_crm_reset;
        host.read(8'hEB, 24'h00_0700, 8'h20, 4, 2);
        keep_is(1'b1, "keep before mode reset");
        @(posedge i_ref_clk) i_crm_reset <= 1'b1;
        @(posedge i_ref_clk) i_crm_reset <= 1'b0;
        host.idle(5);
        keep_is(1'b0, "mode reset");
        host.read(8'hEB, 24'h00_0710, 8'h00, 4, 4);
        stream(19'h0_0710, 2);
    endtask
    task automatic t_freeze;
        host.read(8'hEB, 24'h00_0900, 8'h20, 4, 2);
        keep_is(1'b1, "keep before freeze");
        @(posedge i_ref_clk) i_clk_en <= 1'b0;
        host.read(8'h00, 24'h00_0900, 8'h00, 4, 2);
        keep_is(1'b1, "keep frozen");
        @(posedge i_ref_clk) i_clk_en <= 1'b1;
        keep_is(1'b0, "keep after freeze");
    endtask
    task automatic t_wrap;
        logic [23:0] a;
        for (int l = 0; l < 4; l++) begin
            host.wrap_set({1'b0, 2'(l), 5'h00});
            wl = l;
            settle();
            chk_flag({o_crm_keep, o_wrap_disable, o_wrap_len}, {2'b00, 2'(l)}, "wrap setting");
            a = 24'h00_0240 + 24'((8 << l) - 2);
            for (int k = 0; k < 2; k++) begin
                host.read(k ? 8'hE7 : 8'hEB, a, 8'h00, k ? 2 : 4, 2 * ((8 << l) + 4));
                stream(a[18:0], (8 << l) + 4);
            end
        end
        host.wrap_set(8'h10);
        wl = -1;
        settle();
        chk_flag({o_crm_keep, o_wrap_disable, o_wrap_len}, 4'h4, "wrap off");
        host.read(8'hEB, 24'h00_027E, 8'h00, 4, 8);
        stream(19'h0_027E, 4);
    endtask
    task automatic t_abort;
        host.read(8'hEB, 24'h00_0800, 8'h00, 4, 3);
        chk_flag(o_qd_oe, 4'h0, "lines released");
        stream(19'h0_0800, 1);
    endtask
    task automatic report_and_stop;
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        // a real falling edge, so the link-side flops see the reset too
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        settle();
        chk_flag({o_crm_keep, o_wrap_disable, o_wrap_len}, 4'h4, "reset values");
        // quad enable crosses on serial clock edges only
        host.idle(5);
        t_rollover();
        t_word();
        t_refused();
        t_keep(8'hEB, 4);
        t_keep(8'hE7, 2);
        t_crm_reset();
        t_freeze();
        t_wrap();
        t_abort();
        report_and_stop();
    end
    initial begin
        #300_000;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
